// file: design/oss_pkg.sv
// Constants, register map and field layout for the oscillator and system clock select block.
// Assumes a single 100 MHz clock; all slower rates appear as one-cycle enable pulses.
// Functional notes
// - Three sources exist: a fast internal RC, a slow internal RC near 32kHz and a 32.768kHz crystal.
// - The fast RC runs at 8MHz, 12MHz or 16MHz as fixed by a configuration strap.
// - A configuration strap, not a register, picks slow RC or crystal as the slow clock.
// - The high/low select bit and three-bit divider field pick the system clock at run time.
// - One fast and one slow oscillator are always selected; no setting leaves either without one.
// - A strap gives the two crystal pins to the crystal or to general I/O when the crystal is unused.
// - A strap chooses integrated or external load resistor and capacitors for the crystal.
// - The crystal mode bit selects quick start when 0 and low power when 1.
// - At power-on the crystal mode bit is cleared so the crystal starts in quick-start mode.
// - The crystal runs in either mode; low power only lowers current and lengthens start-up.
// - At power-up the crystal counts as not ready until its start-up delay has elapsed.
// - On sleep or idle the processor clock stops while an independent clock keeps timers running.
// - The selected slow oscillator also clocks the watchdog timer and the time base logic.
package oss_pkg;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int ACC_W = 32;
	localparam int CNT_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] SYS_MODE_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] TIME_BASE_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h08;

	// system_mode_reg fields
	localparam int DIV_SEL_LSB = 5;
	localparam int DIV_SEL_W = 3;
	localparam int SLOW_RDY_BIT = 3;
	localparam int FAST_RDY_BIT = 2;
	localparam int IDLE_EN_BIT = 1;
	localparam int HL_SEL_BIT = 0;
	localparam logic [DIV_SEL_W-1:0] DIV_SEL_RST = 3'h0;
	localparam logic IDLE_EN_RST = 1'b1;
	localparam logic HL_SEL_RST = 1'b1;

	// time_base_control_reg fields
	localparam int XTAL_LP_BIT = 0;
	localparam logic XTAL_LP_RST = 1'b0;

	// Read-only configuration view
	localparam int CFG_FREQ_LSB = 0;
	localparam int CFG_SLOW_XTAL_BIT = 2;
	localparam int CFG_PINS_XTAL_BIT = 3;
	localparam int CFG_INT_LOAD_BIT = 4;

	// Fast RC frequency codes
	typedef enum logic [1:0] {
		FREQ_8M,
		FREQ_12M,
		FREQ_16M,
		FREQ_RSVD
	} oss_freq_t;

	// Source rates
	localparam longint unsigned FAST_8_HZ = 8000000;
	localparam longint unsigned FAST_12_HZ = 12000000;
	localparam longint unsigned FAST_16_HZ = 16000000;
	localparam longint unsigned SLOW_RC_HZ = 32000;

	// Phase accumulator steps: rate * 2^32 / clock rate
	localparam logic [ACC_W-1:0] STEP_8M = ACC_W'((FAST_8_HZ << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] STEP_12M = ACC_W'((FAST_12_HZ << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] STEP_16M = ACC_W'((FAST_16_HZ << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] STEP_SLOW_RC = ACC_W'((SLOW_RC_HZ << ACC_W) / CLK_HZ);

	// Start-up times and derived counts
	localparam int unsigned FAST_START_US = 16;
	localparam logic [CNT_W-1:0] FAST_START_CYC = CNT_W'(FAST_START_US * CYC_PER_US);
	localparam int unsigned SLOW_RC_START_US = 100;
	localparam int unsigned XTAL_QS_START_US = 1000000;
	localparam int unsigned XTAL_LP_START_US = 2000000;

	// Divider codes
	localparam logic [DIV_SEL_W-1:0] DIV_SLOW_MAX = 3'h1;
	localparam int DIV_SHIFT_BASE = 8;
	localparam int DIV_CNT_W = 7;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/oss_rate_gen.sv
// Phase accumulator that turns a step value into one-cycle tick pulses.
// Assumes step is held steady while run is high; ticks come from a register.
`timescale 1ns/1ps
module oss_rate_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic run,
	input wire logic [oss_pkg::ACC_W-1:0] step,
	// Tick out
	output logic tick
);
	import oss_pkg::*;

	logic [ACC_W-1:0] acc_q;
	logic [ACC_W:0] sum;

	assign sum = {1'b0, acc_q} + {1'b0, step};

	always_ff @(posedge clk) begin
		if (!rst_b || !run) begin
			acc_q <= '0;
			tick <= 1'b0;
		end else begin
			acc_q <= sum[ACC_W-1:0];
			tick <= sum[ACC_W];
		end
	end
endmodule

// file: design/oss_clock_select.sv
// Oscillator sources, system clock selection and AXI4-Lite register access.
// Assumes an AXI4-Lite master on clk and pad logic that resolves crystal pin enables.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module oss_clock_select #(
	parameter int unsigned SLOW_RC_START_CYC = oss_pkg::SLOW_RC_START_US * oss_pkg::CYC_PER_US,
	parameter int unsigned XTAL_QS_START_CYC = oss_pkg::XTAL_QS_START_US * oss_pkg::CYC_PER_US,
	parameter int unsigned XTAL_LP_START_CYC = oss_pkg::XTAL_LP_START_US * oss_pkg::CYC_PER_US
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// AXI4-Lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [oss_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [oss_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [oss_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [oss_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// Configuration straps
	input wire logic [1:0] cfgFastFreq,
	input wire logic cfgSlowXtal,
	input wire logic cfgPinsXtal,
	input wire logic cfgIntLoad,
	// Processor state
	input wire logic cpuHalt,
	// Crystal pins
	input wire logic crystalPinAIn,
	output logic crystalPinAOut,
	output logic crystalPinAOe,
	input wire logic crystalPinBIn,
	output logic crystalPinBOut,
	output logic crystalPinBOe,
	// Shared I/O side
	input wire logic [1:0] gpioOut,
	input wire logic [1:0] gpioOe,
	output logic [1:0] gpioIn,
	// Crystal analog controls
	output logic xtalEnable,
	output logic xtalLowPower,
	output logic xtalIntLoad,
	// Clock enables
	output logic cpuClkEn,
	output logic periphClkEn,
	output logic wdtClkEn,
	output logic tbClkEn
);
	import oss_pkg::*;

	function automatic logic [ACC_W-1:0] fastStepOf(input logic [1:0] code);
		case (code)
			FREQ_12M: fastStepOf = STEP_12M;
			FREQ_16M: fastStepOf = STEP_16M;
			default: fastStepOf = STEP_8M;
		endcase
	endfunction

	function automatic logic [DIV_CNT_W-1:0] divRatioOf(input logic [DIV_SEL_W-1:0] sel);
		logic [DIV_CNT_W:0] one;
		one = (DIV_CNT_W+1)'(1);
		divRatioOf = DIV_CNT_W'(one << (DIV_SHIFT_BASE - int'(sel)));
	endfunction

	function automatic logic isSlowSel(input logic hl, input logic [DIV_SEL_W-1:0] sel);
		isSlowSel = !hl && (sel <= DIV_SLOW_MAX);
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////
	// Straps caught while reset is held

	logic [1:0] freq_q;
	logic slowXtal_q, pinsXtal_q, intLoad_q;
	logic [ACC_W-1:0] fastStep;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			freq_q <= cfgFastFreq;
			slowXtal_q <= cfgSlowXtal;
			pinsXtal_q <= cfgPinsXtal || cfgSlowXtal;
			intLoad_q <= cfgIntLoad;
		end
	end

	assign fastStep = fastStepOf(freq_q);
	assign xtalEnable = slowXtal_q;
	assign xtalIntLoad = intLoad_q;

	////////////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [2:0] syncA_q, syncB_q;
	logic pinA_q, pinB_q, pinAPrev_q, xtalTick;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			syncA_q <= '0;
			syncB_q <= '0;
			pinA_q <= 1'b0;
			pinB_q <= 1'b0;
			pinAPrev_q <= 1'b0;
		end else begin
			syncA_q <= {syncA_q[1:0], crystalPinAIn};
			syncB_q <= {syncB_q[1:0], crystalPinBIn};
			if (syncA_q[1] == syncA_q[2])
				pinA_q <= syncA_q[2];
			if (syncB_q[1] == syncB_q[2])
				pinB_q <= syncB_q[2];
			pinAPrev_q <= pinA_q;
		end
	end

	assign xtalTick = slowXtal_q && pinA_q && !pinAPrev_q;
	assign gpioIn = {pinB_q, pinA_q};
	assign crystalPinAOe = !pinsXtal_q && gpioOe[0];
	assign crystalPinBOe = !pinsXtal_q && gpioOe[1];
	assign crystalPinAOut = !pinsXtal_q && gpioOut[0];
	assign crystalPinBOut = !pinsXtal_q && gpioOut[1];

	////////////////////////////////////////////////////////////////////////////////////////
	// Registers and AXI4-Lite slave

	logic hlSel_q, idleEn_q, xtalLp_q;
	logic [DIV_SEL_W-1:0] divSel_q;
	logic awHeld_q, wHeld_q;
	logic [ADDR_W-1:0] wAddr_q;
	logic [DATA_W-1:0] wData_q;
	logic [3:0] wStrb_q;
	logic wrGo, fastReady_q, slowReady_q;
	logic [DATA_W-1:0] sysModeVal, timeBaseVal, configVal;

	assign awready = !awHeld_q && !bvalid;
	assign wready = !wHeld_q && !bvalid;
	assign arready = !rvalid;
	assign wrGo = awHeld_q && wHeld_q && !bvalid;

	assign sysModeVal = DATA_W'({divSel_q, 1'b0, slowReady_q, fastReady_q, idleEn_q, hlSel_q});
	assign timeBaseVal = DATA_W'(xtalLp_q);
	assign configVal = DATA_W'({intLoad_q, pinsXtal_q, slowXtal_q, freq_q});

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			wAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHeld_q <= 1'b1;
				wAddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (wrGo) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (wAddr_q == SYS_MODE_OFS || wAddr_q == TIME_BASE_OFS ||
					wAddr_q == CONFIG_OFS) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hlSel_q <= HL_SEL_RST;
			divSel_q <= DIV_SEL_RST;
			idleEn_q <= IDLE_EN_RST;
		end else if (wrGo && wAddr_q == SYS_MODE_OFS && wStrb_q[0]) begin
			hlSel_q <= wData_q[HL_SEL_BIT];
			divSel_q <= wData_q[DIV_SEL_LSB +: DIV_SEL_W];
			idleEn_q <= wData_q[IDLE_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			xtalLp_q <= XTAL_LP_RST;
		else if (wrGo && wAddr_q == TIME_BASE_OFS && wStrb_q[0])
			xtalLp_q <= wData_q[XTAL_LP_BIT];
	end

	assign xtalLowPower = xtalLp_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			case (araddr)
				SYS_MODE_OFS: rdata <= sysModeVal;
				TIME_BASE_OFS: rdata <= timeBaseVal;
				CONFIG_OFS: rdata <= configVal;
				default: begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Oscillators and start-up tracking

	logic appliedHl_q;
	logic [DIV_SEL_W-1:0] appliedDiv_q;
	logic fastRun, fastTick, slowRcTick, slowTick;
	logic [CNT_W-1:0] fastCnt_q, slowCnt_q, slowTarget;

	// Fast RC stops while the slow clock drives the system and no switch back is pending
	assign fastRun = !isSlowSel(appliedHl_q, appliedDiv_q) || !isSlowSel(hlSel_q, divSel_q);

	oss_rate_gen uFastRc (
		.clk(clk),
		.rst_b(rst_b),
		.run(fastRun),
		.step(fastStep),
		.tick(fastTick)
	);

	oss_rate_gen uSlowRc (
		.clk(clk),
		.rst_b(rst_b),
		.run(!slowXtal_q),
		.step(STEP_SLOW_RC),
		.tick(slowRcTick)
	);

	assign slowTick = (slowXtal_q ? xtalTick : slowRcTick) && slowReady_q;

	always_ff @(posedge clk) begin
		if (!rst_b || !fastRun) begin
			fastCnt_q <= '0;
			fastReady_q <= 1'b0;
		end else if (fastCnt_q >= FAST_START_CYC) begin
			fastReady_q <= 1'b1;
		end else begin
			fastCnt_q <= fastCnt_q + CNT_W'(1);
		end
	end

	// Crystal start-up is longer in low-power mode
	assign slowTarget = !slowXtal_q ? CNT_W'(SLOW_RC_START_CYC) :
		xtalLp_q ? CNT_W'(XTAL_LP_START_CYC) : CNT_W'(XTAL_QS_START_CYC);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			slowCnt_q <= '0;
			slowReady_q <= 1'b0;
		end else if (slowCnt_q >= slowTarget) begin
			slowReady_q <= 1'b1;
		end else begin
			slowCnt_q <= slowCnt_q + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// System clock selection and division

	logic [DIV_CNT_W-1:0] divCnt_q;
	logic appliedSlow, srcTick, sysTick, canSwitch;

	assign appliedSlow = isSlowSel(appliedHl_q, appliedDiv_q);
	assign srcTick = appliedSlow ? slowTick : (fastTick && fastReady_q);
	assign sysTick = srcTick && (appliedSlow || appliedHl_q ||
		divCnt_q == divRatioOf(appliedDiv_q) - DIV_CNT_W'(1));

	// Switch on a period boundary or while the applied fast source is not ready, and only onto a ready fast source
	assign canSwitch = (sysTick || (!appliedSlow && !fastReady_q)) &&
		(isSlowSel(hlSel_q, divSel_q) || fastReady_q);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			appliedHl_q <= HL_SEL_RST;
			appliedDiv_q <= DIV_SEL_RST;
		end else if (canSwitch) begin
			appliedHl_q <= hlSel_q;
			appliedDiv_q <= divSel_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || canSwitch || sysTick)
			divCnt_q <= '0;
		else if (srcTick)
			divCnt_q <= divCnt_q + DIV_CNT_W'(1);
	end

	assign cpuClkEn = sysTick && !cpuHalt;
	assign periphClkEn = sysTick && (!cpuHalt || idleEn_q);
	assign wdtClkEn = slowTick;
	assign tbClkEn = slowTick;

	////////////////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_lp_reset;
		@(posedge clk) !rst_b |=> !xtalLowPower;
	endproperty
	a_lp_reset: assert property (p_lp_reset) else $error("crystal mode not quick start after reset");

	property p_lp_write;
		@(posedge clk) disable iff (!rst_b)
		(wrGo && wAddr_q == TIME_BASE_OFS && wStrb_q[0]) |=>
		(xtalLowPower == $past(wData_q[XTAL_LP_BIT]));
	endproperty
	a_lp_write: assert property (p_lp_write) else $error("crystal mode bit not written");

	property p_slow_not_ready;
		@(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> !slowReady_q [*8];
	endproperty
	a_slow_not_ready: assert property (p_slow_not_ready) else $error("slow source ready too early");

	property p_halt_stops_cpu;
		@(posedge clk) disable iff (!rst_b) cpuHalt |-> !cpuClkEn;
	endproperty
	a_halt_stops_cpu: assert property (p_halt_stops_cpu) else $error("cpu clock during halt");

	property p_slow_feeds_timers;
		@(posedge clk) disable iff (!rst_b)
		(slowReady_q && (slowXtal_q ? xtalTick : slowRcTick)) |-> (wdtClkEn && tbClkEn);
	endproperty
	a_slow_feeds_timers: assert property (p_slow_feeds_timers) else $error("timer tick lost");

	property p_switch_on_boundary;
		@(posedge clk) disable iff (!rst_b)
		($changed(appliedHl_q) || $changed(appliedDiv_q)) |->
		($past(sysTick) || !$past(fastReady_q));
	endproperty
	a_switch_on_boundary: assert property (p_switch_on_boundary) else $error("mid-period switch");

	property p_fast_undivided;
		@(posedge clk) disable iff (!rst_b)
		(appliedHl_q && fastTick && fastReady_q) |-> sysTick;
	endproperty
	a_fast_undivided: assert property (p_fast_undivided) else $error("fast tick not passed");

	property p_fast_step;
		@(posedge clk) disable iff (!rst_b)
		fastStep == (freq_q == FREQ_12M ? STEP_12M : freq_q == FREQ_16M ? STEP_16M : STEP_8M);
	endproperty
	a_fast_step: assert property (p_fast_step) else $error("fast rate wrong for strap");

	property p_xtal_pins_free;
		@(posedge clk) disable iff (!rst_b) pinsXtal_q |-> !crystalPinAOe && !crystalPinBOe;
	endproperty
	a_xtal_pins_free: assert property (p_xtal_pins_free) else $error("crystal pin driven");

	property p_xtal_pins_forced;
		@(posedge clk) disable iff (!rst_b) slowXtal_q |-> pinsXtal_q;
	endproperty
	a_xtal_pins_forced: assert property (p_xtal_pins_forced) else $error("crystal source lacks pins");
endmodule

// file: sim/oss_clock_select_test.sv
// Self-checking bench for the oscillator and system clock select block.
// Assumes the bench alone drives the AXI4-Lite port, straps and pads.
`timescale 1ns/1ps
module oss_clock_select_test;
	import oss_pkg::*;
	logic clk, rst_b;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, cfgFastFreq, gpioOut, gpioOe, gpioIn;
	logic cfgSlowXtal, cfgPinsXtal, cfgIntLoad, cpuHalt, padA, padB, xtalRun;
	logic crystalPinAIn, crystalPinAOut, crystalPinAOe, crystalPinBIn, crystalPinBOut, crystalPinBOe;
	logic xtalEnable, xtalLowPower, xtalIntLoad, cpuClkEn, periphClkEn, wdtClkEn, tbClkEn;
	int n_fail, checks, cntCpu, cntPer, cntWdt, cntTb, minGap, gap;
	logic [DATA_W-1:0] rd;
	logic [1:0] rs;
	assign crystalPinAIn = crystalPinAOe ? crystalPinAOut : padA;
	assign crystalPinBIn = crystalPinBOe ? crystalPinBOut : padB;
	oss_clock_select #(.SLOW_RC_START_CYC(20), .XTAL_QS_START_CYC(40),
		.XTAL_LP_START_CYC(80)) DUT (
		.clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.cfgFastFreq(cfgFastFreq), .cfgSlowXtal(cfgSlowXtal), .cfgPinsXtal(cfgPinsXtal),
		.cfgIntLoad(cfgIntLoad), .cpuHalt(cpuHalt), .crystalPinAIn(crystalPinAIn),
		.crystalPinAOut(crystalPinAOut), .crystalPinAOe(crystalPinAOe),
		.crystalPinBIn(crystalPinBIn), .crystalPinBOut(crystalPinBOut),
		.crystalPinBOe(crystalPinBOe), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn),
		.xtalEnable(xtalEnable), .xtalLowPower(xtalLowPower), .xtalIntLoad(xtalIntLoad),
		.cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .wdtClkEn(wdtClkEn),
		.tbClkEn(tbClkEn));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and crystal stand-in
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		padA = 1'b0;
		forever begin
			repeat (15) @(posedge clk);
			if (xtalRun) begin
				padA <= ~padA;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic timeout(input string what);
		n_fail++;
		$display("MISMATCH %s expected answer seen none", what);
		end_sim();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Bus and stimulus tasks, each entered and left just after a rising edge
	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) return;
		end
		timeout("write response");
	endtask
	task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid === 1'b1 && rready;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) return;
		end
		timeout("read data");
	endtask
	task automatic do_reset(input logic [1:0] f, input logic sx, input logic px, input logic il);
		rst_b <= 1'b0;
		cfgFastFreq <= f;
		cfgSlowXtal <= sx;
		cfgPinsXtal <= px;
		cfgIntLoad <= il;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
	endtask
	task automatic wait_ready(input int b);
		for (int i = 0; i < 400; i++) begin
			axi_read(SYS_MODE_OFS, rd, rs);
			if (rd[b] === 1'b1) return;
			repeat (8) @(posedge clk);
		end
		timeout("oscillator ready");
	endtask
	task automatic count(input int n);
		cntCpu = 0;
		cntPer = 0;
		cntWdt = 0;
		cntTb = 0;
		gap = 1000;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			gap++;
			if (cpuClkEn === 1'b1) begin
				cntCpu++;
				if (gap < minGap) minGap = gap;
				gap = 0;
			end
			if (periphClkEn === 1'b1) cntPer++;
			if (wdtClkEn === 1'b1) cntWdt++;
			if (tbClkEn === 1'b1) cntTb++;
			@(posedge clk);
		end
	endtask
	function automatic logic near(input int seen, input int exp, input int tol);
		return (seen >= exp - tol) && (seen <= exp + tol);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		n_fail = 0; checks = 0; minGap = 1000; gap = 0; xtalRun = 1'b0;
		rst_b = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
		cfgFastFreq = 2'h0; cfgSlowXtal = 0; cfgPinsXtal = 0; cfgIntLoad = 0;
		cpuHalt = 0; padB = 0; gpioOut = 2'h0; gpioOe = 2'h0;
		@(posedge clk);
		do_reset(2'h0, 1'b0, 1'b0, 1'b1);
		axi_read(SYS_MODE_OFS, rd, rs);
		check("mode reset", rd & 32'hfffffff3, 32'h00000003);
		axi_read(TIME_BASE_OFS, rd, rs);
		check("low power reset", rd, 32'h0);
		check("low power pin", xtalLowPower, 1'b0);
		axi_read(CONFIG_OFS, rd, rs);
		check("config view", rd, 32'h00000010);
		axi_read(8'h0c, rd, rs);
		check("unmapped data", rd, 32'h0);
		check("unmapped resp", rs, RESP_SLVERR);
		axi_write(8'h0c, 32'h0, rs);
		check("unmapped write resp", rs, RESP_SLVERR);
		gpioOe <= 2'b01;
		gpioOut <= 2'b01;
		padB <= 1'b1;
		repeat (8) @(posedge clk);
		check("pin drive", {crystalPinAOe, crystalPinAOut, crystalPinBOe, crystalPinBOut},
			4'b1100);
		check("gpio in", gpioIn, 2'b11);
		gpioOut <= 2'b00;
		repeat (8) @(posedge clk);
		check("gpio in low", gpioIn, 2'b10);
		$display("test reset and pins done");
		for (int f = 0; f < 4; f++) begin
			do_reset(f[1:0], 1'b0, 1'b0, 1'b0);
			wait_ready(FAST_RDY_BIT);
			count(1000);
			check("fast rate", near(cntCpu, (f == 1) ? 120 : (f == 2) ? 160 : 80, 2), 1'b1);
		end
		$display("test fast frequencies done");
		for (int c = 7; c >= 2; c--) begin
			axi_write(SYS_MODE_OFS, {24'h0, c[2:0], 5'b00010}, rs);
			check("write resp", rs, RESP_OKAY);
			count(500);
			count(2000);
			check("divided rate", near(cntCpu, 160 >> (8 - c), 2), 1'b1);
		end
		minGap = 1000;
		axi_write(SYS_MODE_OFS, 32'h00000003, rs);
		count(2000);
		check("no short pulse", minGap >= 12, 1'b1);
		$display("test divider done");
		cpuHalt <= 1'b1;
		count(1000);
		check("cpu halted", cntCpu, 0);
		check("periph idle", near(cntPer, 80, 2), 1'b1);
		axi_write(SYS_MODE_OFS, 32'h00000001, rs);
		count(7000);
		check("periph sleep", cntPer, 0);
		check("wdt runs", near(cntWdt, 2, 1), 1'b1);
		check("tb runs", cntTb, cntWdt);
		cpuHalt <= 1'b0;
		$display("test halt done");
		axi_write(SYS_MODE_OFS, 32'h00000022, rs);
		wait_ready(SLOW_RDY_BIT);
		count(400);
		count(10000);
		check("slow rc rate", near(cntCpu, 3, 1), 1'b1);
		axi_read(SYS_MODE_OFS, rd, rs);
		check("fast stopped", rd[FAST_RDY_BIT], 1'b0);
		$display("test slow rc done");
		do_reset(2'h2, 1'b1, 1'b0, 1'b1);
		axi_read(SYS_MODE_OFS, rd, rs);
		check("crystal not ready", rd[SLOW_RDY_BIT], 1'b0);
		check("crystal straps", {xtalEnable, xtalIntLoad, crystalPinAOe, crystalPinBOe},
			4'b1100);
		axi_read(CONFIG_OFS, rd, rs);
		check("crystal config", rd, 32'h0000001e);
		xtalRun <= 1'b1;
		wait_ready(SLOW_RDY_BIT);
		axi_write(SYS_MODE_OFS, 32'h00000002, rs);
		count(200);
		count(600);
		check("crystal cpu", near(cntCpu, 20, 1), 1'b1);
		check("crystal wdt", near(cntWdt, 20, 1), 1'b1);
		axi_write(TIME_BASE_OFS, 32'h00000001, rs);
		axi_read(TIME_BASE_OFS, rd, rs);
		check("low power set", rd, 32'h1);
		check("low power pin set", xtalLowPower, 1'b1);
		count(600);
		check("low power runs", near(cntWdt, 20, 1), 1'b1);
		axi_write(SYS_MODE_OFS, 32'h00000003, rs);
		wait_ready(FAST_RDY_BIT);
		count(100);
		count(1000);
		check("back to fast", near(cntCpu, 160, 2), 1'b1);
		$display("test crystal done");
		end_sim();
	end
endmodule
